// >>> isc_defs.vh
// Purpose: Constants for the two-wire port stop/collision, reload counter and status block
// Assumes: APB byte addresses, 32-bit words, 8-bit registers in low bits
// Notes: Definitions only
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH
`define ISC_OFF_STATUS 12'h000
`define ISC_OFF_RELOAD 12'h004
`define ISC_OFF_BUF 12'h008
`define ISC_OFF_CTRL1 12'h00C
`define ISC_OFF_CTRL2 12'h010
`define ISC_OFF_FLAGS 12'h014
`define ISC_OFF_IRQEN 12'h018
`define ISC_OFF_SLAVE 12'h01C
`define ISC_RST_RELOAD 8'h13
`define ISC_ST_SLEW 7
`define ISC_ST_SMB 6
`define ISC_ST_DATA 5
`define ISC_ST_STOP 4
`define ISC_ST_START 3
`define ISC_ST_RW 2
`define ISC_ST_UA 1
`define ISC_ST_BF 0
`define ISC_C1_EN 5
`define ISC_C2_ACK_SEQUENCE_REQUEST 4
`define ISC_C2_RECEIVE_REQUEST 3
`define ISC_C2_PEN 2
`define ISC_C2_RESTART_REQUEST 1
`define ISC_C2_SEN 0
`define ISC_FL_BCOL 3
`define ISC_FL_PEV 2
`define ISC_SL_RW 0
`define ISC_SL_UA 1
`define ISC_SL_DATA 2
`define ISC_SL_MODE 3
`define ISC_SL_TENBIT 4
`endif

// >>> isc_stop_brg.v
// Purpose: Stop sequence with bus collision checks, reload counter and status register
// Assumes: Pins synchronous to i_clock; open-drain lines low-drive only
// Notes: One APB slave, zero wait states; address/data transmit engine lives elsewhere
//
// Implementation choices: the APB register port and the register addresses.
`include "isc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module isc_stop_brg #(
  parameter ADDR_W = 12
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_sda,
  input wire i_scl,
  output wire o_sda,
  output wire o_sda_oe,
  output wire o_scl,
  output wire o_scl_oe,
  input wire i_start_seen,
  input wire i_stop_seen,
  input wire i_rx_done,
  input wire i_tx_done,
  input wire i_rx_read,
  output wire o_slew_select,
  output wire o_smbus_levels,
  output wire o_reload_tick,
  output wire o_irq
);
  // Stop sequence in outline
  // Launch pulls both lines low together
  // Data seen low lets the clock line go
  // Clock seen high starts the first count
  // First expiry lets the data line float
  // Second expiry samples the data line
  // Data still low there means another master
  // Clock low during the first count means another master
  // Either collision drops both lines at once
  // Either collision clears the stop request bit
  // Either collision clears the buffer full bit
  // A clean finish clears the stop request bit
  // A clean finish stops the counter dead
  //
  // Reload counter timing
  // Counter steps on every second clock only
  // Each value therefore lasts two clocks
  // One expiry spans two times reload plus one
  // Two expiries make one serial clock period
  // So the line runs at clock over four(reload+1)
  // Small reload values give too few clocks per half
  // Software keeps reload at three or above
  //
  // Transmit side of the counter
  // Buffer write in master mode starts the count
  // Transmit done from the engine stops the count
  // Counter then holds; the clock pin keeps its level
  // Buffer writes during a stop are ignored here
  // The byte engine itself lives outside this block
  //
  // Status register in outline
  // Top two bits are writable pin selects
  // Stop and start bits follow the event pulses
  // Both forget their state when the port is off
  // Direction bit shows transmit busy in master mode
  // Direction bit shows the address direction as slave
  // Data and update bits come from the sideband word
  // Buffer full follows writes, receives and reads
  //
  // Hazards worth knowing
  // Line inputs are taken as already synchronous
  // A far party holding clock low stalls the launch
  // A stalled launch waits; no timeout lives here
  // Disabling the port is the way out of a stall
  // Flags are set-wins against a same-cycle clear
  // Stop sequencer states
  localparam S_IDLE = 3'd0;
  localparam S_SDA_LOW = 3'd1;
  localparam S_SCL_REL = 3'd2;
  localparam S_COUNT = 3'd3;
  localparam S_SDA_REL = 3'd4;
  localparam S_COUNT2 = 3'd5;

  reg [7:0] reload_reg;
  reg [7:0] buf_reg;
  reg [7:0] ctrl1_reg;
  reg [7:0] ctrl2_reg;
  reg [1:0] flags_reg;
  reg [1:0] irqen_reg;
  reg [4:0] slave_reg;
  reg slew_reg;
  reg smb_reg;
  reg start_seen_reg;
  reg stop_seen_reg;
  reg bf_reg;
  reg tx_busy_reg;
  reg [7:0] cnt_reg;
  reg cnt_run_reg;
  reg half_reg;
  reg scl_drive_reg;
  reg sda_drive_reg;
  reg [2:0] st_reg;
  reg [2:0] st_next;
  reg bcol_evt;
  reg [31:0] rdata_reg;

  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_en = i_psel & ~i_penable & ~i_pwrite;
  wire port_en = ctrl1_reg[`ISC_C1_EN];
  wire master = ~slave_reg[`ISC_SL_MODE];
  wire cnt_zero = (cnt_reg == 8'h00);
  wire buf_wr = wr_en & (i_paddr == `ISC_OFF_BUF);
  wire stop_go = wr_en & (i_paddr == `ISC_OFF_CTRL2) & i_pwdata[`ISC_C2_PEN];
  // Half-rate step enable sets the two-clock count pace
  wire step = cnt_run_reg & half_reg;
  wire tick = step & cnt_zero;

  // Known-address check shared by read and write error answer
  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = (a == `ISC_OFF_STATUS) | (a == `ISC_OFF_RELOAD) | (a == `ISC_OFF_BUF) |
               (a == `ISC_OFF_CTRL1) | (a == `ISC_OFF_CTRL2) | (a == `ISC_OFF_FLAGS) |
               (a == `ISC_OFF_IRQEN) | (a == `ISC_OFF_SLAVE);
    end
  endfunction

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);
  assign o_prdata = rdata_reg;
  // Lines are only pulled low, never driven high
  assign o_sda = 1'b0;
  assign o_scl = 1'b0;
  assign o_sda_oe = sda_drive_reg;
  assign o_scl_oe = scl_drive_reg;
  assign o_slew_select = slew_reg;
  assign o_smbus_levels = smb_reg;
  assign o_reload_tick = tick;
  // Flag reaches the request line only through its enable
  assign o_irq = |(flags_reg & irqen_reg);

  // Stop sequencer next state and collision decision
  always @* begin
    st_next = st_reg;
    bcol_evt = 1'b0;
    case (st_reg)
      S_IDLE: begin
        if (stop_go & master & port_en) begin
          st_next = S_SDA_LOW;
        end
      end
      S_SDA_LOW: begin
        if (~i_sda) begin
          st_next = S_SCL_REL;
        end
      end
      S_SCL_REL: begin
        if (i_scl) begin
          st_next = S_COUNT;
        end
      end
      S_COUNT: begin
        if (~i_scl) begin
          bcol_evt = 1'b1;
          st_next = S_IDLE;
        end else if (tick) begin
          st_next = S_SDA_REL;
        end
      end
      S_SDA_REL: begin
        if (~i_scl & ~i_sda) begin
          bcol_evt = 1'b1;
          st_next = S_IDLE;
        end else begin
          st_next = S_COUNT2;
        end
      end
      S_COUNT2: begin
        if (tick) begin
          bcol_evt = ~i_sda;
          st_next = S_IDLE;
        end
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
  end

  // Sequencer, line drivers and reload counter
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= S_IDLE;
      sda_drive_reg <= 1'b0;
      scl_drive_reg <= 1'b0;
      cnt_reg <= 8'h00;
      cnt_run_reg <= 1'b0;
      half_reg <= 1'b0;
    end else if (!port_en) begin
      st_reg <= S_IDLE;
      sda_drive_reg <= 1'b0;
      scl_drive_reg <= 1'b0;
      cnt_run_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      // Divider restarts whenever the counter is idle
      half_reg <= cnt_run_reg ? ~half_reg : 1'b0;
      if (bcol_evt) begin
        // Abort releases both lines at once
        sda_drive_reg <= 1'b0;
        scl_drive_reg <= 1'b0;
        cnt_run_reg <= 1'b0;
      end else if (st_reg == S_IDLE && st_next == S_SDA_LOW) begin
        // Clock held low too, so releasing it later means something
        sda_drive_reg <= 1'b1;
        scl_drive_reg <= 1'b1;
      end else if (st_reg == S_SDA_LOW && st_next == S_SCL_REL) begin
        scl_drive_reg <= 1'b0;
      end else if (st_reg == S_SCL_REL && st_next == S_COUNT) begin
        cnt_reg <= reload_reg;
        cnt_run_reg <= 1'b1;
      end else if (st_reg == S_COUNT && st_next == S_SDA_REL) begin
        sda_drive_reg <= 1'b0;
        cnt_reg <= reload_reg;
      end else if (st_next == S_IDLE && st_reg == S_COUNT2) begin
        cnt_run_reg <= 1'b0;
      end else if (buf_wr & master & st_reg == S_IDLE) begin
        cnt_reg <= reload_reg;
        cnt_run_reg <= 1'b1;
      end else if (tx_busy_reg && i_tx_done) begin
        // Transmit over: counter freezes where it stands
        cnt_run_reg <= 1'b0;
      end else if (tick) begin
        // Two reloads per serial clock give Fosc/(4(reload+1))
        cnt_reg <= reload_reg;
      end else if (step) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // Register file writes and hardware status updates
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      reload_reg <= `ISC_RST_RELOAD;
      buf_reg <= 8'h00;
      ctrl1_reg <= 8'h00;
      ctrl2_reg <= 8'h00;
      flags_reg <= 2'b00;
      irqen_reg <= 2'b00;
      slave_reg <= 5'h00;
      slew_reg <= 1'b0;
      smb_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      bf_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
    end else begin
      if (wr_en) begin
        case (i_paddr)
          // Reload values below three are unsupported; software keeps off them
          `ISC_OFF_RELOAD: reload_reg <= i_pwdata[7:0];
          `ISC_OFF_CTRL1: ctrl1_reg <= i_pwdata[7:0];
          `ISC_OFF_CTRL2: ctrl2_reg <= i_pwdata[7:0];
          `ISC_OFF_IRQEN: irqen_reg <= i_pwdata[`ISC_FL_BCOL:`ISC_FL_PEV];
          `ISC_OFF_SLAVE: slave_reg <= i_pwdata[4:0];
          `ISC_OFF_STATUS: begin
            slew_reg <= i_pwdata[`ISC_ST_SLEW];
            smb_reg <= i_pwdata[`ISC_ST_SMB];
          end
          default: begin
          end
        endcase
      end
      // Write-one-to-clear flags; a same-cycle event wins
      if (wr_en && i_paddr == `ISC_OFF_FLAGS) begin
        flags_reg <= (flags_reg & ~i_pwdata[`ISC_FL_BCOL:`ISC_FL_PEV]) |
                     {bcol_evt, i_start_seen | i_stop_seen | i_rx_done | i_tx_done};
      end else begin
        flags_reg <= flags_reg | {bcol_evt, i_start_seen | i_stop_seen | i_rx_done | i_tx_done};
      end
      // Collision clears the stop request and pending transmit
      if (bcol_evt || (st_reg == S_COUNT2 && st_next == S_IDLE)) begin
        ctrl2_reg[`ISC_C2_PEN] <= 1'b0;
      end else if (stop_go) begin
        ctrl2_reg[`ISC_C2_PEN] <= 1'b1;
      end
      // Disabled port forgets bus conditions
      if (!port_en) begin
        start_seen_reg <= 1'b0;
        stop_seen_reg <= 1'b0;
      end else if (i_stop_seen) begin
        stop_seen_reg <= 1'b1;
        start_seen_reg <= 1'b0;
      end else if (i_start_seen) begin
        start_seen_reg <= 1'b1;
        stop_seen_reg <= 1'b0;
      end
      // Buffer full: set on write or receive, cleared on done or read
      if (bcol_evt || !port_en) begin
        bf_reg <= 1'b0;
        tx_busy_reg <= 1'b0;
      end else if (buf_wr && st_reg == S_IDLE) begin
        buf_reg <= i_pwdata[7:0];
        bf_reg <= 1'b1;
        tx_busy_reg <= master;
      end else if (i_rx_done) begin
        bf_reg <= 1'b1;
      end else if (i_tx_done) begin
        bf_reg <= 1'b0;
        tx_busy_reg <= 1'b0;
      end else if (i_rx_read) begin
        bf_reg <= 1'b0;
      end
    end
  end

  // Read mux; status bit 2 differs by mode
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_en) begin
      case (i_paddr)
        `ISC_OFF_STATUS: rdata_reg <= {24'h000000, slew_reg, smb_reg,
          slave_reg[`ISC_SL_DATA],
          stop_seen_reg, start_seen_reg,
          master ? tx_busy_reg : slave_reg[`ISC_SL_RW],
          slave_reg[`ISC_SL_TENBIT] & slave_reg[`ISC_SL_UA],
          bf_reg};
        `ISC_OFF_RELOAD: rdata_reg <= {24'h000000, reload_reg};
        `ISC_OFF_BUF: rdata_reg <= {24'h000000, buf_reg};
        `ISC_OFF_CTRL1: rdata_reg <= {24'h000000, ctrl1_reg};
        `ISC_OFF_CTRL2: rdata_reg <= {24'h000000, ctrl2_reg};
        `ISC_OFF_FLAGS: rdata_reg <= {28'h0000000, flags_reg, 2'b00};
        `ISC_OFF_IRQEN: rdata_reg <= {28'h0000000, irqen_reg, 2'b00};
        `ISC_OFF_SLAVE: rdata_reg <= {27'h0000000, slave_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> isc_bus_far.sv
// Purpose: Far side of the two-wire bus
// Assumes: Pull-ups on both lines
// Notes: Holds stand in for a slow or colliding party
`timescale 1ns/1ps
`default_nettype none
module isc_bus_far (
  input wire logic i_sda_oe,
  input wire logic i_scl_oe,
  input wire logic i_hold_sda,
  input wire logic i_hold_scl,
  output logic o_sda_line,
  output logic o_scl_line
);
  // Wired-AND with pull-up, nobody drives high
  assign o_sda_line = !(i_sda_oe || i_hold_sda);
  assign o_scl_line = !(i_scl_oe || i_hold_scl);
endmodule
`default_nettype wire

// >>> isc_stop_brg_checker.sv
// Purpose: Port checks for the stop and reload block
// Assumes: One clock, async low reset
// Notes: Bound to the block at the foot
`timescale 1ns/1ps
`default_nettype none
module isc_stop_brg_checker #(parameter ADDR_W = 12) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic i_scl,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic o_reload_tick,
  input wire logic o_irq
);
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Access phase and the mapped word range
  wire logic hit = i_psel && i_penable;
  wire logic mapped = i_paddr[1:0] == 2'h0 && i_paddr <= 'h1C;
  sequence quiet3;
    !o_reload_tick [*3];
  endsequence
  // Register writes seen one or two edges back
  logic wr_d1;
  logic wr_d2;
  always @(posedge i_clock) begin
    wr_d1 <= hit && i_pwrite;
    wr_d2 <= wr_d1;
  end
  wire logic wrote = wr_d1 || wr_d2;
  lines_low_only_a: assert property (!o_sda && !o_scl)
    else $error("bus line driven high");
  pready_high_a: assert property (o_pready)
    else $error("pready low");
  slverr_map_a: assert property (hit |-> o_pslverr == !mapped)
    else $error("slverr wrong for address");
  slverr_phase_a: assert property (o_pslverr |-> hit)
    else $error("slverr outside access");
  tick_gap_a: assert property (o_reload_tick |=> quiet3)
    else $error("reload ticks too close");
  reset_quiet_a: assert property ($rose(i_rst_b) |-> !o_sda_oe && !o_scl_oe && !o_irq)
    else $error("outputs busy after reset");
  stop_launch_a: assert property ($rose(o_sda_oe) |-> wrote)
    else $error("data pulled without request");
  sda_release_a: assert property ($fell(o_sda_oe) |->
    o_reload_tick || $past(o_reload_tick) || !i_scl || $past(!i_scl) || wrote)
    else $error("data released off count");
endmodule
bind isc_stop_brg isc_stop_brg_checker #(.ADDR_W(ADDR_W)) u_chk (.i_clock, .i_rst_b, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_scl, .o_pready, .o_pslverr, .o_sda, .o_sda_oe, .o_scl, .o_scl_oe, .o_reload_tick,
  .o_irq);
`default_nettype wire

// >>> isc_stop_brg_test.sv
// Purpose: Self-checking bench for the stop and reload block
// Assumes: Zero-wait APB slave
// Notes: Reload kept at three or more
`timescale 1ns/1ps
`default_nettype none
`include "isc_defs.vh"
module isc_stop_brg_test;
  logic i_clock = 0;
  logic i_rst_b = 0;
  logic i_psel = 0;
  logic i_penable = 0;
  logic i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [4:0] ev = 5'h00;
  logic [1:0] hold = 2'h0;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, o_sda, o_sda_oe, o_scl, o_scl_oe, i_sda, i_scl;
  logic o_slew_select, o_smbus_levels, o_reload_tick, o_irq, err;
  int bad_count = 0;
  int checks = 0;
  int n;
  // 125 MHz clock
  always #4 i_clock = ~i_clock;
  isc_stop_brg u_dut (.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_sda, .i_scl, .o_sda, .o_sda_oe, .o_scl, .o_scl_oe, .i_start_seen(ev[0]),
    .i_stop_seen(ev[1]), .i_rx_done(ev[2]), .i_tx_done(ev[3]), .i_rx_read(ev[4]), .o_slew_select,
    .o_smbus_levels, .o_reload_tick, .o_irq);
  isc_bus_far u_far (.i_sda_oe(o_sda_oe), .i_scl_oe(o_scl_oe), .i_hold_sda(hold[0]), .i_hold_scl(hold[1]),
    .o_sda_line(i_sda), .o_scl_line(i_scl));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One transfer held until pready; ends mid-cycle so pins are settled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'h1;
    do @(posedge i_clock); while (o_pready !== 1'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(negedge i_clock);
  endtask
  task automatic rg(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic pulse(input int b);
    @(posedge i_clock);
    ev <= 5'h01 << b;
    @(posedge i_clock);
    ev <= 5'h00;
  endtask
  task automatic tick_wait(output int k);
    k = 0;
    do begin
      @(negedge i_clock);
      k++;
    end while (o_reload_tick !== 1'h1 && k < 500);
  endtask
  task automatic stop_run(input logic [7:0] rl);
    apb(1'h1, `ISC_OFF_RELOAD, {24'h0, rl});
    apb(1'h1, `ISC_OFF_CTRL2, 32'h4);
    for (int k = 0; k < 200; k++) begin
      rg(`ISC_OFF_CTRL2);
      if (rd[2] === 1'h0) break;
    end
  endtask
  task automatic t_regs;
    rg(`ISC_OFF_STATUS);
    chk("status", rd, 32'h0);
    rg(`ISC_OFF_RELOAD);
    chk("reload", rd, 32'h13);
    rg(12'h020);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'h1, `ISC_OFF_STATUS, 32'hC0);
    chk("pins set", {o_slew_select, o_smbus_levels}, 2'h3);
    apb(1'h1, `ISC_OFF_STATUS, 32'h0);
    chk("pins clr", {o_slew_select, o_smbus_levels}, 2'h0);
    apb(1'h1, `ISC_OFF_SLAVE, 32'h1F);
    rg(`ISC_OFF_STATUS);
    chk("slave", rd & 32'h26, 32'h26);
    apb(1'h1, `ISC_OFF_SLAVE, 32'h0);
    rg(`ISC_OFF_STATUS);
    chk("master", rd & 32'h26, 32'h0);
  endtask
  task automatic t_events;
    apb(1'h1, `ISC_OFF_CTRL1, 32'h20);
    pulse(0);
    rg(`ISC_OFF_STATUS);
    chk("start", rd[4:3], 2'h1);
    pulse(1);
    rg(`ISC_OFF_STATUS);
    chk("stop", rd[4:3], 2'h2);
    apb(1'h1, `ISC_OFF_CTRL1, 32'h0);
    rg(`ISC_OFF_STATUS);
    chk("disabled", rd[4:3], 2'h0);
    apb(1'h1, `ISC_OFF_CTRL1, 32'h20);
    pulse(2);
    rg(`ISC_OFF_STATUS);
    chk("rx full", rd[0], 1'h1);
    pulse(4);
    rg(`ISC_OFF_STATUS);
    chk("rx empty", rd[0], 1'h0);
    apb(1'h1, `ISC_OFF_BUF, 32'h5A);
    tick_wait(n);
    chk("tx count", n < 100, 1'h1);
    rg(`ISC_OFF_STATUS);
    chk("tx busy", rd[2:0], 3'h5);
    pulse(3);
    rg(`ISC_OFF_STATUS);
    chk("tx done", rd[2:0], 3'h0);
  endtask
  task automatic t_stop;
    fork
      stop_run(8'h04);
      begin
        tick_wait(n);
        tick_wait(n);
        chk("spacing", n, 32'hA);
      end
    join
    rg(`ISC_OFF_FLAGS);
    chk("clean", rd[3], 1'h0);
    chk("freed", {o_sda_oe, o_scl_oe}, 2'h0);
    n = 0;
    repeat (60) begin
      @(negedge i_clock);
      if (o_reload_tick !== 1'h0) n++;
    end
    chk("idle", n, 32'h0);
  endtask
  task automatic t_coll;
    @(posedge i_clock);
    hold <= 2'h1;
    stop_run(8'h13);
    @(posedge i_clock);
    hold <= 2'h0;
    rg(`ISC_OFF_FLAGS);
    chk("sda coll", rd[3], 1'h1);
    chk("freed", {o_sda_oe, o_scl_oe}, 2'h0);
    chk("masked", o_irq, 1'h0);
    apb(1'h1, `ISC_OFF_IRQEN, 32'h08);
    chk("irq", o_irq, 1'h1);
    apb(1'h1, `ISC_OFF_FLAGS, 32'h08);
    chk("cleared", o_irq, 1'h0);
    fork
      stop_run(8'h13);
      begin
        do @(negedge i_clock); while (o_sda_oe !== 1'h1);
        repeat (6) @(posedge i_clock);
        hold <= 2'h2;
      end
    join
    @(posedge i_clock);
    hold <= 2'h0;
    rg(`ISC_OFF_FLAGS);
    chk("scl coll", rd[3], 1'h1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    tally_and_finish;
  end
  // Reset, then the scenarios in order
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'h1;
    t_regs;
    t_events;
    t_stop;
    t_coll;
    tally_and_finish;
  end
endmodule
`default_nettype wire
